/* hw/ftsm_regs.vh */
// Behaviour
// - Source bit zero routes the slot to input channel 32 plus its position.
// - Source bit one routes the slot to input channel 40 plus its position.
// - Position field bits 4..2 is a plain binary index, channels 0 to 7.
// - Byte selector bits 1..0: 00 bits 31-24, 01 23-16, 10 15-8, 11 7-0.
// - Each channel has four lanes; a slot fills exactly its chosen lane.
// - 64 output slot maps at 0xF380 to 0xF3BF, resetting to 0x0000.
// - Output slots 0-31 go to output pin two, 32-63 to pin three.
// - Each output slot carries at most one byte of the frame.
// - Output map bits 5..0 pick the supplying audio channel and byte.
// - Input map bit 7 enables the slot; disabled slots write nothing.
// - Input map bit 6 reverses the byte's bit order before placing it.
// - Input map bit 5 picks input pin two (zero) or pin three (one).
// - 64 input slot maps at 0xF300 to 0xF33F, one per byte slot.
`ifndef FTSM_REGS_VH
`define FTSM_REGS_VH

`define FTSM_IN_MAP_BASE     16'hF300
`define FTSM_IN_MAP_LAST     16'hF33F
`define FTSM_OUT_MAP_BASE    16'hF380
`define FTSM_OUT_MAP_LAST    16'hF3BF
`define FTSM_CHAN_RD_BASE    16'hF3C0
`define FTSM_CHAN_RD_LAST    16'hF3DF
`define FTSM_STATUS_ADDR     16'hF3E0
`define FTSM_FRAME_CNT_ADDR  16'hF3E1

`define FTSM_MAP_RESET       8'h00

`define FTSM_SLOT_EN_BIT     7
`define FTSM_REVERSE_BIT     6
`define FTSM_SOURCE_BIT      5
`define FTSM_POS_HI          4
`define FTSM_POS_LO          2
`define FTSM_LANE_HI         1
`define FTSM_LANE_LO         0
`define FTSM_OUT_CHAN_HI     5
`define FTSM_OUT_CHAN_LO     2

`define FTSM_SLOTS           64
`define FTSM_SLOTS_PER_PIN   32
`define FTSM_BITS_PER_SLOT   8
`define FTSM_CHANNELS        16
`define FTSM_CHAN_W          32

`endif

/* hw/ftsm_rx_shift.v */
`timescale 1ns/1ns
module ftsm_rx_shift (
    // Clock and reset.
    input  wire       ref_clk_in,
    input  wire       resetn_in,
    // Serial side.
    input  wire       sample_in,
    input  wire       data_in,
    // Byte completed with the current bit.
    output wire [7:0] byte_out
);

    reg [6:0] shift_r;

    // The newest bit is appended, so the first bit received is the byte's MSB.
    assign byte_out = {shift_r, data_in};

    always @(posedge ref_clk_in) begin
        if (!resetn_in) begin
            shift_r <= 7'h00;
        end else if (sample_in) begin
            shift_r <= {shift_r[5:0], data_in};
        end
    end

endmodule

/* hw/ftsm_tx_shift.v */
`timescale 1ns/1ns
module ftsm_tx_shift (
    // Clock and reset.
    input  wire       ref_clk_in,
    input  wire       resetn_in,
    // Control.
    input  wire       load_in,
    input  wire       shift_in,
    input  wire [7:0] byte_in,
    // Serial pin.
    output reg        pin_out
);

    reg [6:0] shift_r;

    // One byte per slot, sent MSB first.
    always @(posedge ref_clk_in) begin
        if (!resetn_in) begin
            shift_r <= 7'h00;
            pin_out <= 1'b0;
        end else if (load_in) begin
            pin_out <= byte_in[7];
            shift_r <= byte_in[6:0];
        end else if (shift_in) begin
            pin_out <= shift_r[6];
            shift_r <= {shift_r[5:0], 1'b0};
        end
    end

endmodule

/* hw/ftsm_slot_map.v */
`timescale 1ns/1ns
`include "ftsm_regs.vh"
module ftsm_slot_map (
    // Clock and reset.
    input  wire         ref_clk_in,
    input  wire         resetn_in,
    // Register port.
    input  wire [15:0]  reg_addr_in,
    input  wire [15:0]  reg_wdata_in,
    input  wire         reg_wr_in,
    input  wire         reg_rd_in,
    output reg  [15:0]  reg_rdata_out,
    // Serial frame timing.
    input  wire         bclk_in,
    input  wire         fsync_in,
    // Serial data pins.
    input  wire         serial_in_pin_two_in,
    input  wire         serial_in_pin_three_in,
    output wire         serial_out_pin_two_out,
    output wire         serial_out_pin_three_out,
    // Audio channels from the core for output slots.
    input  wire [511:0] audio_out_chan_in,
    // Assembled input channels 32 to 47, channel 32 in the low word.
    output reg  [511:0] audio_in_chan_out,
    output reg          audio_in_frame_out
);

    localparam SLOTS  = `FTSM_SLOTS;
    localparam NCHAN  = `FTSM_CHANNELS;
    localparam CW     = `FTSM_CHAN_W;

    reg  [7:0]  in_map_r  [0:SLOTS-1];
    reg  [7:0]  out_map_r [0:SLOTS-1];
    reg  [31:0] work_r    [0:NCHAN-1];

    reg         bclk_d_r;
    reg  [2:0]  bit_cnt_r;
    reg  [6:0]  slot_cnt_r;
    reg  [15:0] frame_cnt_r;
    reg  [6:0]  last_slots_r;
    reg  [15:0] rdata_nxt;

    wire        bit_rise;
    wire [2:0]  cur_bit;
    wire [6:0]  cur_slot;
    wire        slot_live;
    wire        byte_done;
    wire [7:0]  rx_two_byte;
    wire [7:0]  rx_three_byte;
    wire [7:0]  cur_in_map;
    wire [7:0]  rx_sel_byte;
    wire [7:0]  rx_placed;
    wire [3:0]  rx_chan;
    wire [7:0]  out_map_two;
    wire [7:0]  out_map_three;
    wire [7:0]  tx_two_byte;
    wire [7:0]  tx_three_byte;
    wire        tx_load;
    wire        tx_shift;
    wire        in_map_hit;
    wire        out_map_hit;
    wire        chan_rd_hit;
    wire        frame_start;
    wire        slot_wr;
    wire [5:0]  reg_index;

    wire [511:0] work_flat;

    integer     i;
    genvar      g;

    function [7:0] reverse_byte;
        input [7:0] b;
        integer k;
        begin
            for (k = 0; k < 8; k = k + 1) begin
                reverse_byte[k] = b[7-k];
            end
        end
    endfunction

    function [7:0] lane_of;
        input [31:0] w;
        input [1:0]  lane;
        begin
            case (lane)
                2'h0: lane_of = w[31:24];
                2'h1: lane_of = w[23:16];
                2'h2: lane_of = w[15:8];
                default: lane_of = w[7:0];
            endcase
        end
    endfunction

    // Output slot byte: channel and lane from bits 5..0, optional reversal.
    function [7:0] out_byte;
        input [7:0]   m;
        input [511:0] chans;
        reg   [31:0]  w;
        reg   [7:0]   b;
        begin
            w = chans[m[`FTSM_OUT_CHAN_HI:`FTSM_OUT_CHAN_LO]*CW +: CW];
            b = lane_of(w, m[`FTSM_LANE_HI:`FTSM_LANE_LO]);
            if (m[`FTSM_REVERSE_BIT]) begin
                b = reverse_byte(b);
            end
            if (!m[`FTSM_SLOT_EN_BIT]) begin
                b = 8'h00;
            end
            out_byte = b;
        end
    endfunction

    // Bit clock and frame position tracking.
    assign bit_rise  = bclk_in & ~bclk_d_r;
    assign frame_start = bit_rise & fsync_in;
    assign cur_bit   = fsync_in ? 3'h0 : bit_cnt_r;
    assign cur_slot  = fsync_in ? 7'h00 : slot_cnt_r;
    assign slot_live = (cur_slot < SLOTS);
    assign byte_done = bit_rise & slot_live & (cur_bit == 3'h7);

    // Bit clock history for rise detection.
    always @(posedge ref_clk_in) begin
        if (!resetn_in) begin
            bclk_d_r <= 1'b0;
        end else begin
            bclk_d_r <= bclk_in;
        end
    end

    // Frame pulse, raised in the cycle the new channels are published.
    always @(posedge ref_clk_in) begin
        if (!resetn_in) begin
            audio_in_frame_out <= 1'b0;
        end else begin
            audio_in_frame_out <= frame_start;
        end
    end

    always @(posedge ref_clk_in) begin
        if (!resetn_in) begin
            bit_cnt_r          <= 3'h0;
            slot_cnt_r         <= 7'h40;
            frame_cnt_r        <= 16'h0000;
            last_slots_r       <= 7'h00;
        end else begin
            if (bit_rise) begin
                if (fsync_in) begin
                    bit_cnt_r          <= 3'h1;
                    slot_cnt_r         <= 7'h00;
                    last_slots_r       <= slot_cnt_r;
                    frame_cnt_r        <= frame_cnt_r + 16'h0001;
                end else if (bit_cnt_r == 3'h7) begin
                    bit_cnt_r <= 3'h0;
                    if (slot_cnt_r != 7'h40) begin
                        slot_cnt_r <= slot_cnt_r + 7'h01;
                    end
                end else begin
                    bit_cnt_r <= bit_cnt_r + 3'h1;
                end
            end
        end
    end

    // Input side: one shifter per input pin.
    ftsm_rx_shift u_rx_two (
        .ref_clk_in (ref_clk_in),
        .resetn_in  (resetn_in),
        .sample_in  (bit_rise),
        .data_in    (serial_in_pin_two_in),
        .byte_out   (rx_two_byte)
    );

    ftsm_rx_shift u_rx_three (
        .ref_clk_in (ref_clk_in),
        .resetn_in  (resetn_in),
        .sample_in  (bit_rise),
        .data_in    (serial_in_pin_three_in),
        .byte_out   (rx_three_byte)
    );

    assign cur_in_map  = in_map_r[cur_slot[5:0]];
    assign rx_sel_byte = cur_in_map[`FTSM_SOURCE_BIT] ? rx_three_byte : rx_two_byte;
    assign rx_placed   = cur_in_map[`FTSM_REVERSE_BIT] ? reverse_byte(rx_sel_byte) :
                         rx_sel_byte;
    // Channel index 0..7 is 32 plus position, 8..15 is 40 plus position.
    assign rx_chan     = {cur_in_map[`FTSM_SOURCE_BIT],
                          cur_in_map[`FTSM_POS_HI:`FTSM_POS_LO]};
    assign slot_wr     = byte_done & cur_in_map[`FTSM_SLOT_EN_BIT];

    // Flat view of the work array, channel n in word n.
    generate
        for (g = 0; g < NCHAN; g = g + 1) begin : g_flat
            assign work_flat[g*CW +: CW] = work_r[g];
        end
    endgenerate

    // Assembly: a frame start publishes the work array and clears it.
    always @(posedge ref_clk_in) begin
        if (!resetn_in) begin
            for (i = 0; i < NCHAN; i = i + 1) begin
                work_r[i] <= 32'h0000_0000;
            end
            audio_in_chan_out <= 512'h0;
        end else if (frame_start) begin
            audio_in_chan_out <= work_flat;
            for (i = 0; i < NCHAN; i = i + 1) begin
                work_r[i] <= 32'h0000_0000;
            end
        end else if (slot_wr) begin
            case (cur_in_map[`FTSM_LANE_HI:`FTSM_LANE_LO])
                2'h0: work_r[rx_chan][31:24] <= rx_placed;
                2'h1: work_r[rx_chan][23:16] <= rx_placed;
                2'h2: work_r[rx_chan][15:8]  <= rx_placed;
                default: work_r[rx_chan][7:0] <= rx_placed;
            endcase
        end
    end

    // Output side: slots 0..31 on pin two, 32..63 on pin three.
    assign out_map_two   = out_map_r[{1'b0, cur_slot[4:0]}];
    assign out_map_three = out_map_r[{1'b1, cur_slot[4:0]}];
    assign tx_two_byte   = (cur_slot < `FTSM_SLOTS_PER_PIN) ?
                           out_byte(out_map_two, audio_out_chan_in) : 8'h00;
    assign tx_three_byte = (cur_slot < `FTSM_SLOTS_PER_PIN) ?
                           out_byte(out_map_three, audio_out_chan_in) : 8'h00;
    assign tx_load       = bit_rise & (cur_bit == 3'h0);
    assign tx_shift      = bit_rise & (cur_bit != 3'h0);

    ftsm_tx_shift u_tx_two (
        .ref_clk_in (ref_clk_in),
        .resetn_in  (resetn_in),
        .load_in    (tx_load),
        .shift_in   (tx_shift),
        .byte_in    (tx_two_byte),
        .pin_out    (serial_out_pin_two_out)
    );

    ftsm_tx_shift u_tx_three (
        .ref_clk_in (ref_clk_in),
        .resetn_in  (resetn_in),
        .load_in    (tx_load),
        .shift_in   (tx_shift),
        .byte_in    (tx_three_byte),
        .pin_out    (serial_out_pin_three_out)
    );

    // Register writes; bits 15..8 are not stored.
    assign in_map_hit  = (reg_addr_in >= `FTSM_IN_MAP_BASE) &&
                         (reg_addr_in <= `FTSM_IN_MAP_LAST);
    assign out_map_hit = (reg_addr_in >= `FTSM_OUT_MAP_BASE) &&
                         (reg_addr_in <= `FTSM_OUT_MAP_LAST);
    assign chan_rd_hit = (reg_addr_in >= `FTSM_CHAN_RD_BASE) &&
                         (reg_addr_in <= `FTSM_CHAN_RD_LAST);
    assign reg_index   = reg_addr_in[5:0];

    always @(posedge ref_clk_in) begin
        if (!resetn_in) begin
            for (i = 0; i < SLOTS; i = i + 1) begin
                in_map_r[i]  <= `FTSM_MAP_RESET;
                out_map_r[i] <= `FTSM_MAP_RESET;
            end
        end else if (reg_wr_in) begin
            if (in_map_hit) begin
                in_map_r[reg_index] <= reg_wdata_in[7:0];
            end
            if (out_map_hit) begin
                out_map_r[reg_index] <= reg_wdata_in[7:0];
            end
        end
    end

    // Read data for the addressed register; unmapped addresses read zero.
    always @* begin
        rdata_nxt = 16'h0000;
        if (in_map_hit) begin
            rdata_nxt = {8'h00, in_map_r[reg_index]};
        end else if (out_map_hit) begin
            rdata_nxt = {8'h00, out_map_r[reg_index]};
        end else if (chan_rd_hit) begin
            // Even address is the high half, odd the low half of a channel.
            rdata_nxt = audio_in_chan_out[{reg_addr_in[4:1], ~reg_addr_in[0], 4'h0} +: 16];
        end else if (reg_addr_in == `FTSM_STATUS_ADDR) begin
            rdata_nxt = {5'h00, last_slots_r, bit_cnt_r, slot_live};
        end else if (reg_addr_in == `FTSM_FRAME_CNT_ADDR) begin
            rdata_nxt = frame_cnt_r;
        end
    end

    // Read data stands in the cycle after the strobe only.
    always @(posedge ref_clk_in) begin
        if (!resetn_in) begin
            reg_rdata_out <= 16'h0000;
        end else if (reg_rd_in) begin
            reg_rdata_out <= rdata_nxt;
        end else begin
            reg_rdata_out <= 16'h0000;
        end
    end

endmodule

/* tb/ftsm_slot_map_chk.sv */
`timescale 1ns/1ns
module ftsm_slot_map_chk (
    input wire         ref_clk_in,
    input wire         resetn_in,
    input wire [15:0]  reg_addr_in,
    input wire [15:0]  reg_wdata_in,
    input wire         reg_wr_in,
    input wire         reg_rd_in,
    input wire [15:0]  reg_rdata_out,
    input wire         bclk_in,
    input wire         fsync_in,
    input wire         serial_out_pin_two_out,
    input wire [511:0] audio_in_chan_out,
    input wire         audio_in_frame_out
);
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!resetn_in);
    property p_in_wr_rd;
        reg_wr_in && reg_addr_in >= 16'hF300 && reg_addr_in <= 16'hF33F ##1
        reg_rd_in && reg_addr_in == $past(reg_addr_in) |=>
        reg_rdata_out == (16'h00FF & $past(reg_wdata_in, 2));
    endproperty
    a_in_wr_rd: assert property (p_in_wr_rd) else $error("in map readback");
    property p_out_wr_rd;
        reg_wr_in && reg_addr_in >= 16'hF380 && reg_addr_in <= 16'hF3BF ##1
        reg_rd_in && reg_addr_in == $past(reg_addr_in) |=>
        reg_rdata_out == (16'h00FF & $past(reg_wdata_in, 2));
    endproperty
    a_out_wr_rd: assert property (p_out_wr_rd) else $error("out map readback");
    property p_gap_rd;
        reg_rd_in && reg_addr_in > 16'hF33F && reg_addr_in < 16'hF380 |=> reg_rdata_out == 16'h0000;
    endproperty
    a_gap_rd: assert property (p_gap_rd) else $error("gap read not zero");
    property p_upper_zero;
        reg_rd_in && reg_addr_in >= 16'hF300 && reg_addr_in <= 16'hF3BF |=>
        reg_rdata_out[15:8] == 8'h00;
    endproperty
    a_upper_zero: assert property (p_upper_zero) else $error("map upper byte set");
    property p_frame_once;
        audio_in_frame_out |=> !audio_in_frame_out [*8];
    endproperty
    a_frame_once: assert property (p_frame_once) else $error("frame pulse too long");
    property p_chan_hold;
        !audio_in_frame_out |-> $stable(audio_in_chan_out);
    endproperty
    a_chan_hold: assert property (p_chan_hold) else $error("channels moved mid frame");
    property p_frame_cause;
        audio_in_frame_out |-> $past(fsync_in) && $past(bclk_in);
    endproperty
    a_frame_cause: assert property (p_frame_cause) else $error("frame without sync");
    property p_pin_hold;
        $changed(serial_out_pin_two_out) |-> $past(bclk_in);
    endproperty
    a_pin_hold: assert property (p_pin_hold) else $error("pin moved off bit edge");
endmodule

bind ftsm_slot_map ftsm_slot_map_chk chk_u (
    .ref_clk_in(ref_clk_in), .resetn_in(resetn_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .bclk_in(bclk_in), .fsync_in(fsync_in),
    .serial_out_pin_two_out(serial_out_pin_two_out),
    .audio_in_chan_out(audio_in_chan_out), .audio_in_frame_out(audio_in_frame_out));

/* tb/ftsm_tdm_dev.sv */
`timescale 1ns/1ns
module ftsm_tdm_dev (
    input  wire ref_clk_in,
    input  wire pin_two_in,
    input  wire pin_three_in,
    output reg  bclk_out,
    output reg  fsync_out,
    output reg  pin_two_out,
    output reg  pin_three_out
);
    reg [7:0] rx2 [0:63];
    reg [7:0] rx3 [0:63];
    reg [7:0] q2;
    reg [7:0] q3;
    integer   b;
    integer   s;
    // Sends 64 byte slots MSB first and records both outputs at each bit clock fall.
    initial begin
        bclk_out = 1'b0;
        forever for (b = 0; b < 512; b = b + 1) begin
            s = b / 8;
            q2 = {s[5:0], 2'b01};
            q3 = {~s[5:0], 2'b10};
            fsync_out <= (b == 0);
            pin_two_out <= q2[7 - b % 8];
            pin_three_out <= q3[7 - b % 8];
            repeat (3) @(posedge ref_clk_in);
            bclk_out <= 1'b1;
            repeat (3) @(posedge ref_clk_in);
            rx2[s][7 - b % 8] = pin_two_in;
            rx3[s][7 - b % 8] = pin_three_in;
            bclk_out <= 1'b0;
        end
    end
endmodule

/* tb/tb_flex_tdm_byte_slot_mapper.sv */
`timescale 1ns/1ns
module tb_flex_tdm_byte_slot_mapper;
    reg          ref_clk_in;
    reg          resetn_in;
    reg          reg_wr_in;
    reg          reg_rd_in;
    reg  [15:0]  reg_addr_in;
    reg  [15:0]  reg_wdata_in;
    reg  [511:0] aoc;
    reg  [511:0] exp_ch;
    reg  [7:0]   m;
    reg  [7:0]   v;
    wire [15:0]  rdata;
    wire [511:0] chans;
    wire         bclk, fsync, si2, si3, so2, so3, frame;
    integer      failures, num_checks, k, n;

    ftsm_slot_map dut_u (
        .ref_clk_in(ref_clk_in), .resetn_in(resetn_in), .reg_addr_in(reg_addr_in),
        .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
        .reg_rdata_out(rdata), .bclk_in(bclk), .fsync_in(fsync),
        .serial_in_pin_two_in(si2), .serial_in_pin_three_in(si3),
        .serial_out_pin_two_out(so2), .serial_out_pin_three_out(so3),
        .audio_out_chan_in(aoc), .audio_in_chan_out(chans), .audio_in_frame_out(frame));
    ftsm_tdm_dev dev_u (
        .ref_clk_in(ref_clk_in), .pin_two_in(so2), .pin_three_in(so3), .bclk_out(bclk),
        .fsync_out(fsync), .pin_two_out(si2), .pin_three_out(si3));

    initial begin
        ref_clk_in = 1'b0;
        forever #4 ref_clk_in = ~ref_clk_in;
    end

    task chk(input string what, input [31:0] e, input [31:0] g);
        begin
            num_checks = num_checks + 1;
            if (g !== e) begin
                failures = failures + 1;
                $display("BAD %s expected %h seen %h", what, e, g);
            end
        end
    endtask
    task wr(input [15:0] a, input [15:0] d);
        begin
            reg_wr_in <= 1'b1;
            reg_addr_in <= a;
            reg_wdata_in <= d;
            @(posedge ref_clk_in);
            reg_wr_in <= 1'b0;
            #1;
        end
    endtask
    task rd(input [15:0] a, input [15:0] e);
        begin
            reg_rd_in <= 1'b1;
            reg_addr_in <= a;
            @(posedge ref_clk_in);
            reg_rd_in <= 1'b0;
            #1;
            chk("reg", {16'h0000, e}, {16'h0000, rdata});
        end
    endtask
    task frames(input integer c);
        integer t;
        begin
            for (t = 0; c > 0 && t < 9000; t = t + 1) begin
                @(posedge ref_clk_in);
                #1;
                if (frame === 1'b1) c = c - 1;
            end
            chk("frame", 0, c);
        end
    endtask
    task test_done;
        begin
            $display("checks %0d mismatches %0d", num_checks, failures);
            if (failures == 0 && num_checks > 0)
                $display("TB: PASS");
            else
                $display("TB: FAIL");
            $finish;
        end
    endtask

    initial begin
        #400000;
        failures = failures + 1;
        test_done;
    end

    initial begin
        failures = 0;
        num_checks = 0;
        resetn_in = 1'b0;
        reg_wr_in = 1'b0;
        reg_rd_in = 1'b0;
        reg_addr_in = 16'h0000;
        reg_wdata_in = 16'h0000;
        for (n = 0; n < 16; n = n + 1)
            aoc[n*32 +: 32] = {8'hA0 + n[7:0], 8'hB0 + n[7:0], 8'hC0 + n[7:0], 8'hD0 + n[7:0]};
        repeat (10) @(posedge ref_clk_in);
        resetn_in <= 1'b1;
        @(posedge ref_clk_in);
        rd(16'hF300, 16'h0000);
        rd(16'hF3BF, 16'h0000);
        wr(16'hF33F, 16'hFFA5);
        rd(16'hF33F, 16'h00A5);
        wr(16'hF380, 16'h12C3);
        rd(16'hF380, 16'h00C3);
        wr(16'hF350, 16'h0077);
        rd(16'hF350, 16'h0000);
        $display("test registers done");
        // Every code of position, lane, source and reversal; every third slot disabled.
        exp_ch = 512'h0;
        for (k = 0; k < 64; k = k + 1) begin
            m = (k % 3 == 2) ? (8'h40 | k[7:0]) : {1'b1, k[0], k[5:0]};
            wr(16'hF300 + k[15:0], {8'h00, m});
            v = k[5] ? {~k[5:0], 2'b10} : {k[5:0], 2'b01};
            if (k[0])
                v = {v[0], v[1], v[2], v[3], v[4], v[5], v[6], v[7]};
            if (k % 3 != 2)
                exp_ch[k[5:2]*32 + (3 - k[1:0])*8 +: 8] = v;
        end
        frames(2);
        for (n = 0; n < 16; n = n + 1)
            chk("chan", exp_ch[n*32+:32], chans[n*32+:32]);
        rd(16'hF3C0, exp_ch[31:16]);
        rd(16'hF3DF, exp_ch[495:480]);
        $display("test input slots done");
        wr(16'hF380, 16'h008C);
        wr(16'hF381, 16'h0000);
        wr(16'hF3A0, 16'h0086);
        wr(16'hF3A1, 16'h00FF);
        frames(2);
        chk("pin two slot 0", 32'hA3, dev_u.rx2[0]);
        chk("pin two slot 1", 32'h00, dev_u.rx2[1]);
        chk("pin two slot 40", 32'h00, dev_u.rx2[40]);
        chk("pin three slot 0", 32'hC1, dev_u.rx3[0]);
        chk("pin three slot 1", 32'hFB, dev_u.rx3[1]);
        $display("test output slots done");
        test_done;
    end
endmodule
